//--- verilog/acc_regs.sv
// Channel 3 and channel 4 configuration register bank with decode
`timescale 1ns/100ps
`include "acc_defs.svh"
module acc_regs
   import acc_pkg::*;
#(
   parameter int PH_W = 8
) (
   // Clock, reset and freeze
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // Register access port
   input  wire logic [7:0]        reg_page,
   input  wire logic [7:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   output logic                   reg_ack,
   // Channel 3 trim and delay
   input  wire logic              mod_tick,
   input  wire logic              ch3_sample_in,
   output logic      [3:0]        ch3_gain_trim_code,
   output logic signed [4:0]      ch3_trim_tenth_db,
   output logic      [PH_W-1:0]   ch3_phase_delay_code,
   output logic                   ch3_delayed_sample,
   // Channel 4 raw fields
   output logic                   ch4_input_kind,
   output logic      [1:0]        ch4_source_select,
   output logic                   ch4_coupling_select,
   output logic      [1:0]        ch4_impedance_select,
   output logic                   ch4_auto_level_enable,
   output logic      [5:0]        ch4_coarse_gain_code,
   // Channel 4 decoded controls
   input  wire logic [7:0]        auto_level_global_config,
   output logic                   ch4_analog_diff,
   output logic                   ch4_analog_single,
   output logic                   ch4_pdm_input,
   output logic                   ch4_coupling_select_coupled,
   output logic      [2:0]        ch4_impedance_select_onehot,
   output logic                   ch4_auto_level_active,
   output logic      [5:0]        ch4_coarse_gain_code_db
);

   localparam int DEPTH = 1 << PH_W;   // Delay line length

   // Refuse widths the delay line cannot serve
   if (PH_W != 8) begin : g_bad_width
      $error("acc_regs: phase width must be 8");
   end

   logic [PH_W-1:0] wptr_r;             // Delay line write pointer
   logic            dly_mem [DEPTH];    // Delay line storage
   logic            page_hit;           // Access targets page 0
   logic            wr_trim;            // Write strobes per register
   logic            wr_phase;
   logic            wr_sel;
   logic            wr_gain;
   logic [7:0]      sel_img;            // Read images
   logic [7:0]      gain_img;
   logic [7:0]      trim_img;
   logic [7:0]      rd_nxt;             // Read data next value
   logic            analog_src;         // Analog source chosen

   // Address decode on page 0
   assign page_hit = (reg_page == `ACC_PAGE0);
   assign wr_trim  = ce && reg_wr && page_hit
                     && (reg_addr == `ACC_ADDR_TRIM);
   assign wr_phase = ce && reg_wr && page_hit
                     && (reg_addr == `ACC_ADDR_PHASE);
   assign wr_sel   = ce && reg_wr && page_hit
                     && (reg_addr == `ACC_ADDR_SEL);
   assign wr_gain  = ce && reg_wr && page_hit
                     && (reg_addr == `ACC_ADDR_GAIN);

   // Register images with reserved bits at zero
   assign trim_img = {ch3_gain_trim_code, 4'h0};
   assign sel_img  = {ch4_input_kind, ch4_source_select,
                      ch4_coupling_select, ch4_impedance_select,
                      1'b0, ch4_auto_level_enable};
   assign gain_img = {ch4_coarse_gain_code, 2'h0};
   assign analog_src = (ch4_source_select == ACC_SRC_DIFF)
                       || (ch4_source_select == ACC_SRC_SINGLE);

   // Channel 3 gain trim field
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ch3_gain_trim_code <= 4'(`ACC_RST_TRIM >> `ACC_TRIM_LO);
      end else if (wr_trim) begin
         // Low nibble is reserved and dropped
         ch3_gain_trim_code <= reg_wdata[`ACC_TRIM_HI:`ACC_TRIM_LO];
      end
   end

   // Channel 3 phase delay field
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ch3_phase_delay_code <= PH_W'(`ACC_RST_ZERO);
      end else if (wr_phase) begin
         ch3_phase_delay_code <= PH_W'(reg_wdata & `ACC_MASK_PHASE);
      end
   end

   // Channel 4 input select fields
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ch4_input_kind        <= 1'b0;
         ch4_source_select     <= 2'h0;
         ch4_coupling_select   <= 1'b0;
         ch4_impedance_select  <= 2'h0;
         ch4_auto_level_enable <= 1'b0;
      end else if (wr_sel) begin
         // Bit 1 is reserved and never stored
         ch4_input_kind        <= reg_wdata[`ACC_KIND_BIT];
         ch4_source_select     <= reg_wdata[`ACC_SRC_HI:`ACC_SRC_LO];
         ch4_coupling_select   <= reg_wdata[`ACC_DC_BIT];
         ch4_impedance_select  <= reg_wdata[`ACC_IMP_HI:`ACC_IMP_LO];
         ch4_auto_level_enable <= reg_wdata[`ACC_ALE_BIT];
      end
   end

   // Channel 4 coarse gain field
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ch4_coarse_gain_code <= 6'h00;
      end else if (wr_gain) begin
         ch4_coarse_gain_code <= reg_wdata[`ACC_GAIN_HI:`ACC_GAIN_LO];
      end
   end

   // Read mux, unmapped addresses answer zero
   always_comb begin
      rd_nxt = `ACC_ZERO8;
      if (page_hit) begin
         case (reg_addr)
            `ACC_ADDR_TRIM:  rd_nxt = trim_img & `ACC_MASK_TRIM;
            `ACC_ADDR_PHASE: rd_nxt = 8'(ch3_phase_delay_code);
            `ACC_ADDR_SEL:   rd_nxt = sel_img & `ACC_MASK_SEL;
            `ACC_ADDR_GAIN:  rd_nxt = gain_img & `ACC_MASK_GAIN;
            default:         rd_nxt = `ACC_ZERO8;
         endcase
      end
   end

   // Read data and acknowledge, one cycle after the request
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= `ACC_ZERO8;
         reg_ack   <= 1'b0;
      end else if (ce) begin
         reg_ack <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_nxt;
         end
      end
   end

   // Trim in tenths of a dB: code minus eight
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ch3_trim_tenth_db <= 5'sh00;
      end else if (ce) begin
         ch3_trim_tenth_db <= $signed({1'b0, ch3_gain_trim_code})
                              - $signed(`ACC_TRIM_NEUTRAL);
      end
   end

   // Delay line storage, written on each modulator tick
   always_ff @(posedge ref_clk) begin
      if (ce && mod_tick) begin
         dly_mem[wptr_r] <= ch3_sample_in;
      end
   end

   // Delay line pointer and tapped output
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wptr_r             <= PH_W'(0);
         ch3_delayed_sample <= 1'b0;
      end else if (ce && mod_tick) begin
         wptr_r <= wptr_r + PH_W'(1);
         // Code zero bypasses the line
         if (ch3_phase_delay_code == PH_W'(0)) begin
            ch3_delayed_sample <= ch3_sample_in;
         end else begin
            ch3_delayed_sample <= dly_mem[wptr_r - ch3_phase_delay_code];
         end
      end
   end

   // Source and coupling decode
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ch4_analog_diff   <= 1'b0;
         ch4_analog_single <= 1'b0;
         ch4_pdm_input     <= 1'b0;
         ch4_coupling_select_coupled    <= 1'b0;
      end else if (ce) begin
         // Reserved source code selects nothing
         ch4_analog_diff   <= ch4_source_select == ACC_SRC_DIFF;
         ch4_analog_single <= ch4_source_select == ACC_SRC_SINGLE;
         ch4_pdm_input     <= ch4_source_select == ACC_SRC_PDM;
         // Coupling ignored for digital input
         ch4_coupling_select_coupled    <= analog_src && ch4_coupling_select;
      end
   end

   // Impedance one-hot decode, analog sources only
   for (genvar i = 0; i < 3; i++) begin : g_imp
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            ch4_impedance_select_onehot[i] <= 1'b0;
         end else if (ce) begin
            ch4_impedance_select_onehot[i] <= analog_src
                              && (ch4_impedance_select == 2'(i));
         end
      end
   end

   // Auto level gating and gain clamp
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ch4_auto_level_active <= 1'b0;
         ch4_coarse_gain_code_db           <= 6'h00;
      end else if (ce) begin
         ch4_auto_level_active <= ch4_auto_level_enable
            && auto_level_global_config[`ACC_GLOBAL_ALE_BIT];
         // Reserved codes held at the top step
         if (ch4_coarse_gain_code > `ACC_GAIN_MAX) begin
            ch4_coarse_gain_code_db <= `ACC_GAIN_MAX;
         end else begin
            ch4_coarse_gain_code_db <= ch4_coarse_gain_code;
         end
      end
   end

   // Write of input select then read back
   sequence s_sel_write;
      ce && reg_wr && page_hit && (reg_addr == `ACC_ADDR_SEL)
      && !reg_rd;
   endsequence
   sequence s_sel_read;
      ce && reg_rd && !reg_wr && page_hit
      && (reg_addr == `ACC_ADDR_SEL);
   endsequence

   // Trim output follows code minus eight
   property p_trim_map;
      @(posedge ref_clk) disable iff (rst)
      ce |=> (ch3_trim_tenth_db
              == $signed({1'b0, $past(ch3_gain_trim_code)})
                 - $signed(`ACC_TRIM_NEUTRAL));
   endproperty
   a_trim_map: assert property (p_trim_map)
      else $error("trim output not code minus eight");

   // Trim stays within minus eight to plus seven
   property p_trim_span;
      @(posedge ref_clk) disable iff (rst)
      (ch3_trim_tenth_db >= -$signed(`ACC_TRIM_NEUTRAL))
      && (ch3_trim_tenth_db < $signed(`ACC_TRIM_NEUTRAL));
   endproperty
   a_trim_span: assert property (p_trim_span)
      else $error("trim outside span");

   // Zero phase code passes the sample on the same tick, one clock later
   property p_phase_zero;
      @(posedge ref_clk) disable iff (rst)
      (ce && mod_tick && ch3_phase_delay_code == 8'h00)
      |=> (ch3_delayed_sample == $past(ch3_sample_in));
   endproperty
   a_phase_zero: assert property (p_phase_zero)
      else $error("zero phase code added delay");

   // Source decode is one-hot or empty for reserved
   property p_source;
      @(posedge ref_clk) disable iff (rst)
      ce ##1 ce |-> $onehot0({ch4_analog_diff, ch4_analog_single,
                              ch4_pdm_input})
         && (ch4_pdm_input == ($past(ch4_source_select) == 2'h2));
   endproperty
   a_source: assert property (p_source)
      else $error("source decode wrong");

   // No DC coupling with digital input
   property p_coupling;
      @(posedge ref_clk) disable iff (rst)
      ch4_pdm_input |-> !ch4_coupling_select_coupled && (ch4_impedance_select_onehot == 3'h0);
   endproperty
   a_coupling: assert property (p_coupling)
      else $error("analog settings active for digital input");

   // Reserved impedance code selects no impedance
   property p_imp;
      @(posedge ref_clk) disable iff (rst)
      (ce && ch4_impedance_select == 2'h3) |=> (ch4_impedance_select_onehot == 3'h0);
   endproperty
   a_imp: assert property (p_imp)
      else $error("reserved impedance decoded");

   // Auto level runs only with both enables
   property p_auto_level;
      @(posedge ref_clk) disable iff (rst)
      ce |=> (ch4_auto_level_active == ($past(ch4_auto_level_enable)
              && $past(auto_level_global_config[`ACC_GLOBAL_ALE_BIT])));
   endproperty
   a_auto_level: assert property (p_auto_level)
      else $error("auto level gating wrong");

   // Gain never exceeds 42 dB and tracks legal codes
   property p_gain;
      @(posedge ref_clk) disable iff (rst)
      (ce && ch4_coarse_gain_code <= `ACC_GAIN_MAX)
      |=> (ch4_coarse_gain_code_db == $past(ch4_coarse_gain_code))
          && (ch4_coarse_gain_code_db <= `ACC_GAIN_MAX);
   endproperty
   a_gain: assert property (p_gain)
      else $error("coarse gain decode wrong");

   // Reset leaves trim at neutral and others at zero
   property p_reset_vals;
      @(posedge ref_clk)
      $fell(rst) |-> (ch3_gain_trim_code == 4'h8)
         && (ch3_phase_delay_code == 8'h00) && (sel_img == 8'h00)
         && (gain_img == 8'h00);
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("reset values wrong");

   // Input select written then read returns masked data
   property p_sel_rw;
      logic [7:0] d;
      @(posedge ref_clk) disable iff (rst)
      (s_sel_write, d = reg_wdata) ##1 s_sel_read
      |=> reg_ack && (reg_rdata == (d & `ACC_MASK_SEL));
   endproperty
   a_sel_rw: assert property (p_sel_rw)
      else $error("input select readback wrong");

   // Reserved trim bits always read zero
   property p_reserved;
      @(posedge ref_clk) disable iff (rst)
      reg_ack && $past(reg_addr) == `ACC_ADDR_TRIM && $past(page_hit)
      |-> (reg_rdata[3:0] == 4'h0);
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved trim bits read nonzero");

endmodule

//--- verilog/acc_defs.svh
// Register map, field positions and reset values of the channel config bank
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
// Register page and addresses
`define ACC_PAGE0          8'h00
`define ACC_ADDR_TRIM      8'h49
`define ACC_ADDR_PHASE     8'h4A
`define ACC_ADDR_SEL       8'h4B
`define ACC_ADDR_GAIN      8'h4C
// Reset values
`define ACC_RST_TRIM       8'h80
`define ACC_RST_ZERO       8'h00
// Writable bit masks, reserved bits cleared
`define ACC_MASK_TRIM      8'hF0
`define ACC_MASK_PHASE     8'hFF
`define ACC_MASK_SEL       8'hFD
`define ACC_MASK_GAIN      8'hFC
// Field positions
`define ACC_TRIM_HI        7
`define ACC_TRIM_LO        4
`define ACC_KIND_BIT       7
`define ACC_SRC_HI         6
`define ACC_SRC_LO         5
`define ACC_DC_BIT         4
`define ACC_IMP_HI         3
`define ACC_IMP_LO         2
`define ACC_ALE_BIT        0
`define ACC_GAIN_HI        7
`define ACC_GAIN_LO        2
`define ACC_GLOBAL_ALE_BIT 3
// Trim and gain figures
`define ACC_TRIM_NEUTRAL   5'h08
`define ACC_GAIN_MAX       6'h2A
`define ACC_ZERO8          8'h00
`endif

//--- verilog/acc_pkg.sv
// Types shared by the channel configuration bank
package acc_pkg;
   // Channel input source codes
   typedef enum logic [1:0] {
      ACC_SRC_DIFF   = 2'h0,
      ACC_SRC_SINGLE = 2'h1,
      ACC_SRC_PDM    = 2'h2,
      ACC_SRC_RSVD   = 2'h3
   } acc_src_e;
   // Impedance codes
   typedef enum logic [1:0] {
      ACC_IMP_2K5  = 2'h0,
      ACC_IMP_10K  = 2'h1,
      ACC_IMP_20K  = 2'h2,
      ACC_IMP_RSVD = 2'h3
   } acc_imp_e;
endpackage

//--- verif/acc_host_model.sv
// Host controller model driving the bank's register port
`timescale 1ns/100ps
`include "acc_defs.svh"
module acc_host_model (
   // Clock
   input  wire logic       ref_clk,
   // Register port towards the bank
   output logic [7:0]      reg_page,
   output logic [7:0]      reg_addr,
   output logic            reg_wr,
   output logic [7:0]      reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_ack
);
   // Shared pins are not modelled
   // Quiet port at time zero, qualifiers off page 0
   initial begin
      reg_page  = 8'hFF;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end
   // Drop strobes, scramble qualifiers so stale values never match
   task automatic idle_bus();
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_page  <= ~reg_page;
      reg_addr  <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
   endtask
   // One-cycle write strobe
   task automatic write_reg(input logic [7:0] pg, ad, dt);
      logic [7:0] d;
      d = dt;
      // Reserved gain codes are never sent
      if (pg == `ACC_PAGE0 && ad == `ACC_ADDR_GAIN && d[7:2] > `ACC_GAIN_MAX)
         d[7:2] = `ACC_GAIN_MAX;
      @(posedge ref_clk);
      reg_page  <= pg;
      reg_addr  <= ad;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      idle_bus();
   endtask
   // Page 0 write, then a read of the same address on the next cycle
   task automatic write_read(input logic [7:0] ad, dt,
                             output logic [7:0] d, output logic a);
      @(posedge ref_clk);
      reg_page  <= `ACC_PAGE0;
      reg_addr  <= ad;
      reg_wdata <= dt;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge ref_clk);
      idle_bus();
      #1;
      d = reg_rdata;
      a = reg_ack;
   endtask
   // One-cycle read strobe, answer taken one cycle later
   task automatic read_reg(input logic [7:0] pg, ad,
                           output logic [7:0] d, output logic a);
      @(posedge ref_clk);
      reg_page <= pg;
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      idle_bus();
      #1;
      d = reg_rdata;
      a = reg_ack;
   endtask
endmodule

//--- verif/acc_regs_tb_top.sv
// Self-checking bench for the channel configuration register bank
`timescale 1ns/100ps
`include "acc_defs.svh"
module acc_regs_tb_top;
   import acc_pkg::*;
   // Bench-driven inputs
   logic ref_clk, rst, ce, mod_tick, ch3_sample_in;
   logic [7:0] auto_level_global_config;
   // Register port
   logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata;
   logic       reg_wr, reg_rd, reg_ack;
   // Channel outputs
   logic [3:0] ch3_gain_trim_code;
   logic signed [4:0] ch3_trim_tenth_db;
   logic [7:0] ch3_phase_delay_code;
   logic       ch3_delayed_sample, ch4_input_kind, ch4_coupling_select;
   logic [1:0] ch4_source_select, ch4_impedance_select;
   logic       ch4_auto_level_enable, ch4_analog_diff, ch4_analog_single;
   logic       ch4_pdm_input, ch4_coupling_select_coupled, ch4_auto_level_active;
   logic [5:0] ch4_coarse_gain_code, ch4_coarse_gain_code_db;
   logic [2:0] ch4_impedance_select_onehot;
   int         bad_count = 0;
   int         compares = 0;

   acc_regs #(.PH_W(8)) dut_u (.ref_clk, .rst, .ce, .reg_page, .reg_addr,
      .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_ack, .mod_tick,
      .ch3_sample_in, .ch3_gain_trim_code, .ch3_trim_tenth_db,
      .ch3_phase_delay_code, .ch3_delayed_sample, .ch4_input_kind,
      .ch4_source_select, .ch4_coupling_select, .ch4_impedance_select,
      .ch4_auto_level_enable, .ch4_coarse_gain_code,
      .auto_level_global_config, .ch4_analog_diff, .ch4_analog_single,
      .ch4_pdm_input, .ch4_coupling_select_coupled, .ch4_impedance_select_onehot,
      .ch4_auto_level_active, .ch4_coarse_gain_code_db);
   acc_host_model hm_u (.ref_clk, .reg_page, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rd, .reg_rdata, .reg_ack);

   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Value compare, counted
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   // Read and compare data and acknowledge
   task automatic rchk(string nm, logic [7:0] pg, ad, e);
      logic [7:0] d;
      logic       a;
      hm_u.read_reg(pg, ad, d, a);
      chk(nm, e, d);
      chk("ack", 8'h01, {7'h00, a});
   endtask
   // Let field and decode stages land
   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   // Reset values and map
   task automatic t_reset();
      rchk("trim_rst", 8'h00, `ACC_ADDR_TRIM, 8'h80);
      rchk("phase_rst", 8'h00, `ACC_ADDR_PHASE, 8'h00);
      rchk("sel_rst", 8'h00, `ACC_ADDR_SEL, 8'h00);
      rchk("gain_rst", 8'h00, `ACC_ADDR_GAIN, 8'h00);
      chk("trim_tenth_rst", 8'h00, 8'(ch3_trim_tenth_db));
   endtask
   // Every trim code, reserved low nibble written as ones
   task automatic t_trim();
      logic [4:0] t;
      for (int c = 0; c < 16; c++) begin
         hm_u.write_reg(8'h00, `ACC_ADDR_TRIM, {c[3:0], 4'hF});
         settle();
         t = {1'b0, c[3:0]} - 5'h08;
         chk("trim_code", {4'h0, c[3:0]}, {4'h0, ch3_gain_trim_code});
         chk("trim_tenth", {3'h0, t}, {3'h0, ch3_trim_tenth_db});
         rchk("trim_rd", 8'h00, `ACC_ADDR_TRIM, {c[3:0], 4'h0});
      end
   endtask
   // All sources and impedances, global gate toggled
   task automatic t_sel();
      logic [7:0] d;
      logic [7:0] e;
      logic       an;
      logic       a;
      for (int s = 0; s < 4; s++) begin
         for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            auto_level_global_config <= i[0] ? 8'h08 : 8'hF7;
            d = {s[0], s[1:0], 1'b1, i[1:0], 1'b1, s[1]};
            hm_u.write_reg(8'h00, `ACC_ADDR_SEL, d);
            settle();
            an = (s < 2);
            e = {s == 0, s == 1, s == 2, an, 3'h0, s[1] & i[0]};
            if (an && i < 3)
               e[3:1] = 3'h1 << i;
            chk("sel_raw", d & 8'hFD, {ch4_input_kind, ch4_source_select,
               ch4_coupling_select, ch4_impedance_select, 1'b0,
               ch4_auto_level_enable});
            chk("sel_dec", e, {ch4_analog_diff, ch4_analog_single,
               ch4_pdm_input, ch4_coupling_select_coupled, ch4_impedance_select_onehot,
               ch4_auto_level_active});
            rchk("sel_rd", 8'h00, `ACC_ADDR_SEL, d & 8'hFD);
         end
      end
      // Write then read on the very next cycle sees the new value
      hm_u.write_read(`ACC_ADDR_SEL, 8'hB7, d, a);
      chk("sel_b2b", 8'hB5, d);
      chk("sel_b2b_ack", 8'h01, {7'h00, a});
   endtask
   // Gain boundaries, reserved low bits written as ones
   task automatic t_gain();
      logic [5:0] gc [4] = '{6'h00, 6'h01, 6'h29, 6'h2A};
      foreach (gc[k]) begin
         hm_u.write_reg(8'h00, `ACC_ADDR_GAIN, {gc[k], 2'h3});
         settle();
         chk("gain_code", {2'h0, gc[k]}, {2'h0, ch4_coarse_gain_code});
         chk("gain_db", {2'h0, gc[k]}, {2'h0, ch4_coarse_gain_code_db});
         rchk("gain_rd", 8'h00, `ACC_ADDR_GAIN, {gc[k], 2'h0});
      end
   endtask
   // Foreign pages, unmapped addresses, frozen enable
   task automatic t_unmap();
      hm_u.write_reg(8'h00, `ACC_ADDR_SEL, 8'h00);
      hm_u.write_reg(8'h01, `ACC_ADDR_SEL, 8'hFF);
      hm_u.write_reg(8'h00, 8'h4D, 8'hFF);
      @(posedge ref_clk);
      ce <= 1'b0;
      hm_u.write_reg(8'h00, `ACC_ADDR_PHASE, 8'h5A);
      @(posedge ref_clk);
      ce <= 1'b1;
      rchk("sel_keep", 8'h00, `ACC_ADDR_SEL, 8'h00);
      rchk("page1_rd", 8'h01, `ACC_ADDR_SEL, 8'h00);
      rchk("addr4d_rd", 8'h00, 8'h4D, 8'h00);
      rchk("frozen_wr", 8'h00, `ACC_ADDR_PHASE, 8'h00);
   endtask
   // Delay line at zero, small and full-scale codes
   task automatic t_phase();
      logic       hist [0:511];
      logic [7:0] nv [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
      logic       b;
      foreach (nv[j]) begin
         hm_u.write_reg(8'h00, `ACC_ADDR_PHASE, nv[j]);
         rchk("phase_rd", 8'h00, `ACC_ADDR_PHASE, nv[j]);
         chk("phase_code", nv[j], ch3_phase_delay_code);
         for (int k = 0; k < nv[j] + 7; k++) begin
            b = k[0] ^ k[2] ^ k[5];
            hist[k] = b;
            @(posedge ref_clk);
            mod_tick <= 1'b1;
            ch3_sample_in <= b;
            @(posedge ref_clk);
            mod_tick <= 1'b0;
            ch3_sample_in <= ~b;
            #1;
            if (k >= nv[j])
               chk("delayed", {7'h0, hist[k - nv[j]]},
                   {7'h0, ch3_delayed_sample});
         end
      end
   endtask
   // Counts, verdict, end of run
   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard, well beyond the expected run of under a thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      wrap_up();
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      mod_tick = 1'b0;
      ch3_sample_in = 1'b0;
      auto_level_global_config = 8'h00;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_trim();
      t_sel();
      t_gain();
      t_unmap();
      t_phase();
      wrap_up();
   end
endmodule
